// *** dv/gate_cmd_fsm_chk.sv ***
// assertion checker for the gate command state machine
`default_nettype none
module gate_cmd_fsm_chk
   import gate_cmd_pkg::*;
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rstn,
   // watched ports
   input wire logic        auto_close_en,
   input wire gate_in_t    pins,
   input wire gate_limit_t limits,
   input wire gate_out_t   gate_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // short names for the motion outputs
   wire logic ro = gate_out.run_open;
   wire logic rc = gate_out.run_close;
   wire logic lk = gate_out.locked;

   ////////////////////////////////////////////////////////////////////////////////
   one_direction_a: assert property (!(ro && rc))
      else $error("both directions driven");
   lock_quiet_a: assert property (lk |-> gate_out.alarm && !ro && !rc)
      else $error("lockout without alarm or with motion");
   // the reset input needs three edges to reach the outputs
   lock_stays_a: assert property ((lk && !pins.lockout_reset)[*5] |=> lk)
      else $error("lockout left without reset");
   open_starts_a: assert property ($rose(pins.open_cmd) && !lk && !limits.open_limit
      && !pins.opening_obstruction_sense |-> ##[1:12] ro)
      else $error("open command did not open");
   close_starts_a: assert property ($rose(pins.close_cmd) && !ro && !rc && !lk
      && !limits.close_limit && pins[9:4] == 6'h10 && !pins.open_loop |-> ##[1:6] rc)
      else $error("close command did not close");
   stop_halts_a: assert property ($rose(pins.stop_cmd) && (ro || rc) && !pins.open_cmd
      && !pins.open_loop |-> ##[1:6] !ro && !rc)
      else $error("stop command ignored");
   held_open_a: assert property (pins.open_cmd[*4] ##0 ($rose(pins.stop_cmd) && ro)
      |-> ##5 (ro || limits.open_limit))
      else $error("held open did not override stop");
   held_noclose_a: assert property ((pins.open_cmd && !pins.opening_obstruction_sense)[*8]
      |-> !rc)
      else $error("closing while open held");
   close_reopen_a: assert property (($rose(pins.reverse_command) || $rose(pins.reverse_loop)
      || $rose(pins.closing_obstruction_sense)) && rc && !limits.close_limit
      |-> ##[1:6] !rc ##[1:10] (ro || lk))
      else $error("no reversal to open");
   obstruct_back_a: assert property ($rose(pins.opening_obstruction_sense) && ro
      && !limits.open_limit |-> ##[1:6] !ro ##[1:10] (rc || lk))
      else $error("no short reversal on obstruction");
   entrap_lock_a: assert property ($rose(pins.open_entrapment) && ro && !limits.open_limit
      |-> ##[1:6] lk)
      else $error("entrapment during reopen not locked");

   // main scenarios reached
   cover property ($rose(lk));
   cover property ($fell(rc) ##[1:10] ro);
   cover property (auto_close_en && $fell(limits.open_limit));
   cover property ($fell(ro) ##[1:10] rc);
endmodule : gate_cmd_fsm_chk

bind gate_cmd_fsm gate_cmd_fsm_chk u_chk (.core_clk(core_clk), .rstn(rstn),
   .auto_close_en(auto_close_en), .pins(pins), .limits(limits), .gate_out(gate_out));
`default_nettype wire

// *** dv/gate_plant.sv ***
// gate leaf and limit switch model driven by the motion outputs
`default_nettype none
module gate_plant
   import gate_cmd_pkg::*;
#(
   parameter int TRAVEL = 30
)
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // motion in, limit switches out
   input  wire gate_out_t   gate_out,
   output var  gate_limit_t limits
);
   timeunit 1ns;
   timeprecision 100ps;
   int pos;

   // one step a cycle; the leaf rests against a stop rather than overrun it
   always @(posedge core_clk)
      if (!rstn)
         pos <= 0;
      else if (gate_out.run_open && pos < TRAVEL)
         pos <= pos + 1;
      else if (gate_out.run_close && pos > 0)
         pos <= pos - 1;

   // switches close only at the end stops
   assign limits.open_limit  = (pos == TRAVEL);
   assign limits.close_limit = (pos == 0);
endmodule : gate_plant
`default_nettype wire

// *** dv/test_gate_command_input_fsm.sv ***
// self-checking bench for the gate command state machine
`default_nettype none
module test_gate_command_input_fsm
   import gate_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int AC = 20;
   localparam int RO = 4, RC = 3, AL = 2, LK = 1, CL = 5, OL = 6, AH = 0;
   localparam logic [9:0] M_OPEN = 10'h200, M_CLOSE = 10'h100, M_STOP = 10'h080;
   localparam logic [9:0] M_REV = 10'h040, M_OOBS = 10'h020, M_COBS = 10'h010;
   localparam logic [9:0] M_ENT = 10'h008, M_LOOP = 10'h004, M_RLOOP = 10'h002;
   localparam logic [9:0] M_RST = 10'h001;
   logic        core_clk;
   logic        rstn;
   logic        auto_close_en;
   gate_in_t    pins;
   gate_limit_t limits;
   gate_out_t   gate_out;
   wire logic [6:0] obs = {limits, gate_out};
   logic [9:0]  rev_m [3] = '{M_REV, M_RLOOP, M_COBS};
   int          fails;
   int          check_count;
   int          w;

   gate_cmd_fsm #(.SHORT_REV_CYC(32'h8), .STOP_PAUSE_CYC(32'h4), .AUTO_CLOSE_CYC(32'h14)) dut
      (.core_clk(core_clk), .rstn(rstn), .auto_close_en(auto_close_en), .pins(pins),
       .limits(limits), .gate_out(gate_out));
   gate_plant u_plant (.core_clk(core_clk), .rstn(rstn), .gate_out(gate_out), .limits(limits));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // random width keeps each pulse above the two-cycle visibility floor
   task automatic pulse(input logic [9:0] m);
      @(posedge core_clk) pins <= pins | m;
      repeat ($urandom_range(6, 3)) @(posedge core_clk);
      pins <= pins & ~m;
   endtask : pulse

   // bounded wait on one observed bit, sampled on the falling edge
   task automatic wt(input int b, input logic v, input int n);
      int k;
      k = 0;
      while (obs[b] !== v && k < n)
      begin
         @(negedge core_clk);
         k++;
      end
      chk(obs[b], v);
   endtask : wt

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////////
   // free-running clock
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // a hang costs far more than the whole sequence needs
   initial
   begin
      #(25 * 8000);
      fails++;
      results();
   end

   // main sequence
   initial
   begin
      rstn = 1'b0;
      auto_close_en = 1'b0;
      pins = '0;
      fails = 0;
      check_count = 0;
      w = $urandom(87098);
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      pulse(M_OPEN);
      wt(RO, 1, 12);
      wt(OL, 1, 60);
      wt(RO, 0, 8);
      $display("done open");
      for (int i = 0; i < 3; i++)
      begin
         pulse(M_CLOSE);
         wt(RC, 1, 12);
         repeat ($urandom_range(12, 6)) @(posedge core_clk);
         pulse(rev_m[i]);
         wt(RC, 0, 8);
         wt(RO, 1, 16);
         wt(OL, 1, 60);
      end
      $display("done reversals");
      pulse(M_CLOSE);
      wt(RC, 1, 12);
      repeat (15) @(posedge core_clk);
      pulse(M_STOP);
      wt(RC, 0, 8);
      repeat (10) @(negedge core_clk);
      chk(obs[RC], 0);
      @(posedge core_clk) pins <= pins | M_OPEN;
      wt(RO, 1, 12);
      pulse(M_STOP);
      repeat (4) @(negedge core_clk);
      chk(obs[RO], 1);
      wt(OL, 1, 60);
      @(posedge core_clk) auto_close_en <= 1'b1;
      repeat (AC + 20) @(negedge core_clk);
      chk(obs[RC], 0);
      chk(obs[AH], 1);
      @(posedge core_clk) pins <= pins & ~M_OPEN;
      wt(RC, 1, AC + 20);
      wt(CL, 1, 60);
      $display("done stop and hold");
      for (int i = 0; i < 2; i++)
      begin
         if (i == 0)
            @(posedge core_clk) pins <= pins | M_LOOP;
         else
            pulse(M_OPEN);
         wt(OL, 1, 60);
         @(posedge core_clk) pins <= pins | (i == 0 ? 10'h000 : M_COBS);
         repeat (AC + 20) @(negedge core_clk);
         chk(obs[RC], 0);
         @(posedge core_clk) pins <= pins & ~(M_LOOP | M_COBS);
         wt(RC, 1, AC + 20);
         wt(CL, 1, 60);
      end
      $display("done auto close");
      pulse(M_OPEN);
      wt(RO, 1, 12);
      pulse(M_OOBS);
      wt(RO, 0, 8);
      wt(RC, 1, 12);
      wt(RC, 0, 16);
      repeat (AC + 20) @(negedge core_clk);
      chk({obs[RO], obs[RC]}, 0);
      chk(obs[AH], 1);
      pulse(M_OPEN);
      wt(RO, 1, 12);
      pulse(M_OOBS);
      wt(LK, 1, 10);
      chk(obs[AL], 1);
      pulse(M_OPEN);
      repeat (8) @(negedge core_clk);
      chk({obs[RO], obs[RC], obs[LK]}, 1);
      pulse(M_RST);
      wt(LK, 0, 10);
      chk(obs[AL], 0);
      $display("done obstruction lockout");
      @(posedge core_clk) auto_close_en <= 1'b0;
      pulse(M_OPEN);
      wt(OL, 1, 60);
      pulse(M_CLOSE);
      wt(RC, 1, 12);
      repeat (8) @(posedge core_clk);
      pulse(M_COBS);
      wt(RO, 1, 16);
      pulse(M_ENT);
      wt(LK, 1, 10);
      pulse(M_RST);
      wt(LK, 0, 10);
      $display("done reopen lockout");
      results();
   end
endmodule : test_gate_command_input_fsm
`default_nettype wire

// *** hdl/auto_close_timer.sv ***
// auto-close countdown with hold and cancel
`default_nettype none
`include "gate_cmd_defs.svh"
module auto_close_timer
#(
   parameter logic [`CNT_W-1:0] AUTO_CLOSE_CYC = `AUTO_CLOSE_CYC
)
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // control
   input  wire logic enable,
   input  wire logic start,
   input  wire logic hold,
   input  wire logic cancel,
   // result
   output var  logic expired
);

   logic [`CNT_W-1:0] cnt_r;
   logic              run_r;

   // counts only while armed and not held; expired is a one-cycle pulse
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         cnt_r   <= '0;
         run_r   <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (cancel || !enable)
         begin
            run_r <= 1'b0;
            cnt_r <= '0;
         end
         else if (start)
         begin
            run_r <= 1'b1;
            cnt_r <= '0;
         end
         else if (run_r && !hold)
         begin
            if (cnt_r >= AUTO_CLOSE_CYC - 1)
            begin
               run_r   <= 1'b0;
               expired <= 1'b1;
            end
            else
               cnt_r <= cnt_r + 1'b1;
         end
      end
   end

endmodule : auto_close_timer
`default_nettype wire

// *** hdl/gate_cmd_defs.svh ***
// timing and count constants for the gate command state machine
`ifndef GATE_CMD_DEFS_SVH
`define GATE_CMD_DEFS_SVH

// core clock rate in hertz
`define CORE_CLK_HZ         40000000
// short reversal after an opening obstruction, in milliseconds
`define SHORT_REV_MS        500
`define SHORT_REV_CYC       ((`CORE_CLK_HZ / 1000) * `SHORT_REV_MS)
// pause between stop and reversal, in milliseconds
`define STOP_PAUSE_MS       250
`define STOP_PAUSE_CYC      ((`CORE_CLK_HZ / 1000) * `STOP_PAUSE_MS)
// auto-close hold time, in seconds
`define AUTO_CLOSE_S        30
`define AUTO_CLOSE_CYC      (`CORE_CLK_HZ * `AUTO_CLOSE_S)
// width of the timing counters
`define CNT_W               32

`endif

// *** hdl/gate_cmd_fsm.sv ***
// command input state machine of a swing-gate controller
`default_nettype none
`include "gate_cmd_defs.svh"
module gate_cmd_fsm
   import gate_cmd_pkg::*;
#(
   parameter logic [`CNT_W-1:0] SHORT_REV_CYC  = `SHORT_REV_CYC,
   parameter logic [`CNT_W-1:0] STOP_PAUSE_CYC = `STOP_PAUSE_CYC,
   parameter logic [`CNT_W-1:0] AUTO_CLOSE_CYC = `AUTO_CLOSE_CYC
)
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // configuration strap, steady level
   input  wire logic        auto_close_en,
   // contact and detector inputs, asynchronous
   input  wire gate_in_t    pins,
   input  wire gate_limit_t limits,
   // motion decision
   output var  gate_out_t   gate_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // input conditioning

   localparam int IN_W = $bits(gate_in_t) + $bits(gate_limit_t);

   logic [IN_W-1:0] sync_q;
   gate_in_t        in_s;
   gate_limit_t     lim_s;
   gate_in_t        in_d_r;

   pin_sync #(
      .W (IN_W)
   ) u_sync (
      .core_clk     (core_clk),
      .rstn         (rstn),
      .pin_in       ({pins, limits}),
      .pin_sync_out (sync_q)
   );

   assign in_s  = gate_in_t'(sync_q[IN_W-1:$bits(gate_limit_t)]);
   assign lim_s = gate_limit_t'(sync_q[$bits(gate_limit_t)-1:0]);

   // previous levels for edge detection of momentary commands
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         in_d_r <= '0;
      else
         in_d_r <= in_s;
   end

   function automatic logic rise(input logic now_v, input logic was_v);
      rise = now_v && !was_v;
   endfunction : rise

   wire open_rise   = rise(in_s.open_cmd, in_d_r.open_cmd);
   wire close_rise  = rise(in_s.close_cmd, in_d_r.close_cmd);
   wire stop_rise   = rise(in_s.stop_cmd, in_d_r.stop_cmd);
   wire oobs_rise   = rise(in_s.opening_obstruction_sense, in_d_r.opening_obstruction_sense);
   wire cobs_rise   = rise(in_s.closing_obstruction_sense, in_d_r.closing_obstruction_sense);
   wire entrap_rise = rise(in_s.open_entrapment, in_d_r.open_entrapment);
   wire rev_rise    = rise(in_s.reverse_command, in_d_r.reverse_command);
   wire rloop_rise  = rise(in_s.reverse_loop, in_d_r.reverse_loop);
   wire oloop_rise  = rise(in_s.open_loop, in_d_r.open_loop);

   // held open level from the open input or station open button, or the exit loop
   wire open_held   = in_s.open_cmd || in_s.open_loop;
   wire any_open    = open_rise || oloop_rise;
   wire reopen_trig = rev_rise || rloop_rise || cobs_rise;
   wire open_fault  = oobs_rise || entrap_rise;

   ////////////////////////////////////////////////////////////////////////////////
   // state machine

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_OPENING,
      ST_CLOSING,
      ST_OBS_PAUSE,
      ST_SHORT_REV,
      ST_OBS_HALT,
      ST_REV_PAUSE,
      ST_REOPEN,
      ST_LOCKOUT
   } state_t;

   state_t            state_r;
   state_t            state_nxt;
   logic [`CNT_W-1:0] cnt_r;
   logic              rev_dir_close_r;   // short reversal direction
   logic              rev_dir_close_nxt;
   logic              strike_r;          // one opening obstruction already seen
   logic              strike_nxt;
   logic              ac_block_r;        // auto-close disabled after obstruction or lockout reset
   logic              ac_block_nxt;
   logic              ac_start;
   logic              ac_expired;

   wire at_open   = lim_s.open_limit;
   wire at_close  = lim_s.close_limit;
   wire pause_end = (cnt_r >= STOP_PAUSE_CYC - 1);
   wire rev_end   = (cnt_r >= SHORT_REV_CYC - 1);
   wire moving    = (state_r == ST_OPENING) || (state_r == ST_CLOSING);

   // next-state decision; priority: lockout, obstruction, reversal, open command, stop
   always_comb
   begin
      state_nxt         = state_r;
      rev_dir_close_nxt = rev_dir_close_r;
      strike_nxt        = strike_r;
      ac_block_nxt      = ac_block_r;
      ac_start          = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            if (any_open && !at_open)
            begin
               state_nxt    = ST_OPENING;
               ac_block_nxt = 1'b0;
            end
            else if (close_rise && !at_close && !open_held)
            begin
               state_nxt    = ST_CLOSING;
               ac_block_nxt = 1'b0;
            end
            else if (ac_expired && !at_close && !open_held)
               state_nxt = ST_CLOSING;
         end
         ST_OPENING:
         begin
            if (oobs_rise && strike_r)
               state_nxt = ST_LOCKOUT;
            else if (oobs_rise)
            begin
               state_nxt         = ST_OBS_PAUSE;
               rev_dir_close_nxt = 1'b1;
               strike_nxt        = 1'b1;
            end
            else if (cobs_rise)
               state_nxt = ST_REV_PAUSE;
            else if (stop_rise && !open_held)
               state_nxt = ST_IDLE;
            else if (at_open)
            begin
               state_nxt  = ST_IDLE;
               strike_nxt = 1'b0;
               ac_start   = 1'b1;
            end
         end
         ST_CLOSING:
         begin
            if (oobs_rise && strike_r)
               state_nxt = ST_LOCKOUT;
            else if (oobs_rise)
            begin
               state_nxt         = ST_OBS_PAUSE;
               rev_dir_close_nxt = 1'b0;
               strike_nxt        = 1'b1;
            end
            else if (reopen_trig)
               state_nxt = ST_REV_PAUSE;
            else if (any_open)
               state_nxt = ST_OPENING;
            else if (stop_rise)
               state_nxt = ST_IDLE;
            else if (at_close)
            begin
               state_nxt  = ST_IDLE;
               strike_nxt = 1'b0;
            end
         end
         ST_OBS_PAUSE:
         begin
            if (pause_end)
               state_nxt = ST_SHORT_REV;
         end
         ST_SHORT_REV:
         begin
            if (rev_end || (rev_dir_close_r ? at_close : at_open))
            begin
               state_nxt    = ST_OBS_HALT;
               ac_block_nxt = 1'b1;
            end
         end
         ST_OBS_HALT:
         begin
            // a renewed command re-arms auto-close for the next rest at the open limit
            if (any_open && !at_open)
            begin
               state_nxt    = ST_OPENING;
               ac_block_nxt = 1'b0;
            end
            else if (close_rise && !at_close)
            begin
               state_nxt    = ST_CLOSING;
               ac_block_nxt = 1'b0;
            end
         end
         ST_REV_PAUSE:
         begin
            if (pause_end)
               state_nxt = ST_REOPEN;
         end
         ST_REOPEN:
         begin
            if (open_fault)
               state_nxt = ST_LOCKOUT;
            else if (at_open)
            begin
               state_nxt  = ST_IDLE;
               strike_nxt = 1'b0;
               ac_start   = 1'b1;
            end
         end
         ST_LOCKOUT:
         begin
            if (in_s.lockout_reset)
            begin
               state_nxt    = ST_IDLE;
               strike_nxt   = 1'b0;
               ac_block_nxt = 1'b1;
            end
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // state register and phase counter; counter restarts on every state change
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         state_r         <= ST_IDLE;
         cnt_r           <= '0;
         rev_dir_close_r <= 1'b0;
         strike_r        <= 1'b0;
         ac_block_r      <= 1'b0;
      end
      else
      begin
         state_r         <= state_nxt;
         cnt_r           <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
         rev_dir_close_r <= rev_dir_close_nxt;
         strike_r        <= strike_nxt;
         ac_block_r      <= ac_block_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // auto-close timer

   // held while an open request or loop is present, or the closing beam is blocked;
   // cancelled while opening or closing so a stale expiry never closes a moving gate
   wire ac_hold   = open_held || in_s.closing_obstruction_sense;
   wire ac_cancel = moving || ac_block_r || (state_r == ST_LOCKOUT);

   auto_close_timer #(
      .AUTO_CLOSE_CYC (AUTO_CLOSE_CYC)
   ) u_ac (
      .core_clk (core_clk),
      .rstn     (rstn),
      .enable   (auto_close_en),
      .start    (ac_start),
      .hold     (ac_hold),
      .cancel   (ac_cancel && !ac_start),
      .expired  (ac_expired)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   wire drive_open  = (state_nxt == ST_OPENING) || (state_nxt == ST_REOPEN)
                   || ((state_nxt == ST_SHORT_REV) && !rev_dir_close_nxt);
   wire drive_close = (state_nxt == ST_CLOSING)
                   || ((state_nxt == ST_SHORT_REV) && rev_dir_close_nxt);

   // registered so the motor stage never sees a decode glitch
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         gate_out <= '0;
      else
      begin
         gate_out.run_open        <= drive_open;
         gate_out.run_close       <= drive_close;
         gate_out.alarm           <= (state_nxt == ST_LOCKOUT);
         gate_out.locked          <= (state_nxt == ST_LOCKOUT);
         gate_out.auto_close_hold <= ac_hold || ac_block_nxt;
      end
   end

endmodule : gate_cmd_fsm
`default_nettype wire

// *** hdl/gate_cmd_pkg.sv ***
// types shared by the gate command state machine
`default_nettype none
package gate_cmd_pkg;

   // conditioned command and sensor inputs, all active high
   typedef struct packed {
      logic open_cmd;
      logic close_cmd;
      logic stop_cmd;
      logic reverse_command;
      logic opening_obstruction_sense;
      logic closing_obstruction_sense;
      logic open_entrapment;
      logic open_loop;
      logic reverse_loop;
      logic lockout_reset;
   } gate_in_t;

   // travel limit switches
   typedef struct packed {
      logic open_limit;
      logic close_limit;
   } gate_limit_t;

   // motion decision driven to the motor stage
   typedef struct packed {
      logic run_open;
      logic run_close;
      logic alarm;
      logic locked;
      logic auto_close_hold;
   } gate_out_t;

endpackage : gate_cmd_pkg
`default_nettype wire

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for a bundle of slow pins
`default_nettype none
module pin_sync
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rstn,
   // pins in and synchronised levels out
   input  wire logic [W-1:0] pin_in,
   output var  logic [W-1:0] pin_sync_out
);

   logic [W-1:0] meta_r;

   // first stage feeds the second only
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         meta_r       <= '0;
         pin_sync_out <= '0;
      end
      else
      begin
         meta_r       <= pin_in;
         pin_sync_out <= meta_r;
      end
   end

endmodule : pin_sync
`default_nettype wire
